//--- sdpi_pkg.sv
// Shared constants and carrier types of the step and direction pulse input.
package sdpi_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses of aligned 32-bit words
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  OFF_MODE       = 8'h00;
   localparam logic [7:0]  OFF_SUBTYPE    = 8'h04;
   localparam logic [7:0]  OFF_NUMER      = 8'h08;
   localparam logic [7:0]  OFF_DENOM      = 8'h0C;
   localparam logic [7:0]  OFF_POS        = 8'h10;
   localparam logic [7:0]  OFF_FE_WINDOW  = 8'h14;
   localparam logic [7:0]  OFF_FE_TIMEOUT = 8'h18;
   localparam logic [7:0]  OFF_STATUS     = 8'h1C;
   localparam logic [7:0]  OFF_EVENT      = 8'h20;
   localparam logic [7:0]  OFF_MASK       = 8'h24;
   localparam logic [7:0]  OFF_INVERT     = 8'h28;
   localparam logic [7:0]  OFF_LIMIT_EN   = 8'h2C;
   localparam logic [7:0]  OFF_POLE_PAIRS = 8'h30;
   localparam logic [7:0]  OFF_STEPS_REV  = 8'h34;
   localparam logic [7:0]  OFF_IN_LEVEL   = 8'h38;

   // ----------------------------------------------------------------
   // Field positions, codes and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  MODE_PULSE     = 8'hFF;
   localparam logic        SUB_PLUS_DIR   = 1'b0;
   localparam logic        SUB_DUAL_ROT   = 1'b1;
   localparam logic [15:0] NUMER_RESET    = 16'h0080;
   localparam logic [15:0] DENOM_RESET    = 16'h0001;
   localparam logic [15:0] FULL_STEP      = 16'h0200;
   localparam logic [7:0]  POLE_PAIRS_RST = 8'h32;
   localparam int unsigned STEPS_PER_PP_SHIFT = 2;
   localparam int unsigned SW_MODE_ACTIVE = 0;
   localparam int unsigned SW_DIV_BUSY    = 1;
   localparam int unsigned SW_FOLLOW_ERR  = 13;
   localparam int unsigned NIN            = 6;
   localparam int unsigned IN_NEG_LIMIT   = 0;
   localparam int unsigned IN_DIRECTION   = 1;
   localparam int unsigned IN_PULSE       = 2;
   localparam int unsigned HEX_W          = 4;
   localparam int unsigned EVT_W          = 4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned DIR_SETUP_NS   = 35000;
   localparam int unsigned DIR_SETUP_CYC  = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIR_SETUP_W    = $clog2(DIR_SETUP_CYC + 1);
   localparam int unsigned MS_NS          = 1000000;
   localparam int unsigned TICK_CYC       = MS_NS / CLK_PERIOD_NS;

   // Sticky events, one bit each, same layout in the event register and mask.
   typedef struct packed {
      logic limit;
      logic spacing;
      logic follow;
      logic pulse;
   } sdpi_evt_t;

endpackage

//--- sdpi_step_src.sv
// Behavioural positioning controller that sends step pulses to the pulse input.
`timescale 1ns/1ps
module sdpi_step_src (
   output logic [1:0] lines
);
   // -----------------------------------------------------------------
   // Pulse source
   // -----------------------------------------------------------------
   // Bit 1 drives input 2 and bit 0 drives input 1. Lines stand still between bursts.
   initial begin
      lines = 2'h0;
   end

   // The pulse timing is free running in ns, unrelated in phase to the system clock.
   task automatic burst(input int n, input logic dir, input logic dual);
      if (!dual && dir !== lines[0]) begin
         lines[0] = dir;
         #36000;
      end
      for (int i = 0; i < n; i++) begin
         #37;
         if (dual && !dir)
            lines[0] = 1'b1;
         else
            lines[1] = 1'b1;
         #400;
         lines = dual ? 2'h0 : {1'b0, lines[0]};
         #800;
      end
   endtask

   // Breaks the direction setup time on purpose, so the bench can see the spacing flag.
   task automatic hasty(input logic dir);
      lines[0] = dir;
      #2000;
      lines[1] = 1'b1;
      #400;
      lines[1] = 1'b0;
      #800;
   endtask
endmodule

//--- sdpi_top.sv
// Step and direction pulse input: pin conditioning, step scaling, position and registers.
`timescale 1ns/1ps

module sdpi_top #(
   parameter int unsigned POS_W         = 32,
   parameter int unsigned RATIO_W       = 16,
   parameter int unsigned TICK_CYCLES   = sdpi_pkg::TICK_CYC,
   parameter logic [3:0]  HEX_MODE_CODE = 4'h1
) (
   input  wire logic                           clk,
   input  wire logic                           reset_n,
   input  wire logic [sdpi_pkg::ADDR_W-1:0]    addr,
   input  wire logic [31:0]                    wdata,
   input  wire logic                           wr_en,
   input  wire logic                           rd_en,
   output logic      [31:0]                    rd_data,
   input  wire logic [sdpi_pkg::NIN-1:0]       in_pin,
   input  wire logic [sdpi_pkg::HEX_W-1:0]     hex_pin,
   input  wire logic                           closed_loop,
   input  wire logic [POS_W-1:0]               act_pos,
   output logic      [POS_W-1:0]               cmd_pos,
   output logic                                mode_active,
   output logic                                follow_err,
   output logic                                irq
);

   localparam int unsigned NSYNC = sdpi_pkg::NIN + sdpi_pkg::HEX_W;
   localparam int unsigned TW    = $clog2(TICK_CYCLES);

   if (POS_W < 16 || POS_W > 32 || RATIO_W < 8 || RATIO_W > 16 || TICK_CYCLES < 2) begin : g_bad
      $error("sdpi_top: unsupported parameter values");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0][NSYNC-1:0]             sy;
      logic [NSYNC-1:0]                  lvl;
      logic [7:0]                        mode;
      logic                              sub;
      logic [RATIO_W-1:0]                num;
      logic [RATIO_W-1:0]                den;
      logic [RATIO_W-1:0]                step_q;
      logic [RATIO_W-1:0]                step_r;
      logic [RATIO_W-1:0]                frac;
      logic                              dv_busy;
      logic [5:0]                        dv_cnt;
      logic [RATIO_W-1:0]                dv_a;
      logic [RATIO_W-1:0]                dv_q;
      logic signed [POS_W-1:0]           pos;
      logic [sdpi_pkg::DIR_SETUP_W-1:0]  spc;
      logic [TW-1:0]                     tick_cnt;
      logic                              tick;
      logic [POS_W-1:0]                  fe_win;
      logic [15:0]                       fe_tmo;
      logic [15:0]                       fe_cnt;
      logic                              fe;
      sdpi_pkg::sdpi_evt_t               evt;
      logic [sdpi_pkg::EVT_W-1:0]        mask;
      logic [sdpi_pkg::NIN-1:0]          inv;
      logic [1:0]                        lim_en;
      logic [7:0]                        pp;
      logic                              modeact;
      logic [31:0]                       rd_data;
      logic                              irq;
   } sdpi_state_t;

   sdpi_state_t                s;
   sdpi_state_t                n;
   logic [NSYNC-1:0]           rise;
   logic [sdpi_pkg::NIN-1:0]   cond;
   logic [sdpi_pkg::NIN-1:0]   inv_eff;
   logic                       pulse_f;
   logic                       pulse_r;
   logic                       blocked;
   logic                       mv_f;
   logic                       mv_r;
   logic [RATIO_W-1:0]         den_eff;
   logic [RATIO_W:0]           a_sh;
   logic [RATIO_W:0]           fr;
   logic [RATIO_W:0]           inc;
   logic signed [POS_W-1:0]    diff;
   logic [POS_W-1:0]           absd;
   logic [31:0]                rdv;
   logic signed [31:0]         pos_rd;
   sdpi_pkg::sdpi_evt_t        ev;

   assign pos_rd = 32'(s.pos);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      n       = s;
      a_sh    = '0;
      fr      = '0;
      inc     = '0;
      ev      = '0;
      rdv     = '0;
      pulse_f = 1'b0;
      pulse_r = 1'b0;
      blocked = 1'b0;
      mv_f    = 1'b0;
      mv_r    = 1'b0;

      // Three stages per input; a level is accepted once stages two and three agree.
      n.sy[0] = {hex_pin, in_pin};
      n.sy[1] = s.sy[0];
      n.sy[2] = s.sy[1];
      for (int i = 0; i < NSYNC; i++) begin
         rise[i] = s.sy[1][i] & s.sy[2][i] & ~s.lvl[i];
         if (s.sy[1][i] == s.sy[2][i]) begin
            n.lvl[i] = s.sy[2][i];
         end
      end

      n.modeact = (s.mode == sdpi_pkg::MODE_PULSE)
                | (s.lvl[sdpi_pkg::NIN +: sdpi_pkg::HEX_W] == HEX_MODE_CODE);

      // Pulse and direction pins never see the polarity setting in this mode.
      inv_eff = s.inv;
      if (s.modeact) begin
         inv_eff[sdpi_pkg::IN_PULSE]     = 1'b0;
         inv_eff[sdpi_pkg::IN_DIRECTION] = 1'b0;
      end
      cond = s.lvl[sdpi_pkg::NIN-1:0] ^ inv_eff;

      // Pulse decoding per subtype.
      if (s.modeact) begin
         if (s.sub == sdpi_pkg::SUB_PLUS_DIR) begin
            pulse_f = rise[sdpi_pkg::IN_PULSE] & s.lvl[sdpi_pkg::IN_DIRECTION];
            pulse_r = rise[sdpi_pkg::IN_PULSE] & ~s.lvl[sdpi_pkg::IN_DIRECTION];
         end else begin
            // Edges on both inputs in one cycle cancel out.
            pulse_f = rise[sdpi_pkg::IN_PULSE] & ~rise[sdpi_pkg::IN_DIRECTION];
            pulse_r = rise[sdpi_pkg::IN_DIRECTION] & ~rise[sdpi_pkg::IN_PULSE];
         end
      end
      blocked = (pulse_f & s.lim_en[1] & cond[sdpi_pkg::IN_DIRECTION])
              | (pulse_r & s.lim_en[0] & cond[sdpi_pkg::IN_NEG_LIMIT]);
      mv_f = pulse_f & ~blocked;
      mv_r = pulse_r & ~blocked;
      ev.limit = blocked;
      ev.pulse = mv_f | mv_r;

      // A pulse too soon after a direction change is still counted but flagged.
      if (s.spc != '0) begin
         n.spc = s.spc - 1'b1;
      end
      if (s.modeact && s.sub == sdpi_pkg::SUB_PLUS_DIR &&
          n.lvl[sdpi_pkg::IN_DIRECTION] != s.lvl[sdpi_pkg::IN_DIRECTION]) begin
         n.spc = sdpi_pkg::DIR_SETUP_W'(sdpi_pkg::DIR_SETUP_CYC);
      end
      ev.spacing = (pulse_f | pulse_r) & (s.spc != '0);

      // Whole part and remainder of the ratio keep the position exact over many pulses.
      den_eff = (s.den == '0) ? RATIO_W'(1) : s.den;
      if (mv_f) begin
         fr  = {1'b0, s.frac} + {1'b0, s.step_r};
         inc = {1'b0, s.step_q};
         if (fr >= {1'b0, den_eff}) begin
            fr  = fr - {1'b0, den_eff};
            inc = inc + 1'b1;
         end
         n.frac = fr[RATIO_W-1:0];
         n.pos  = s.pos + POS_W'(inc);
      end else if (mv_r) begin
         inc = {1'b0, s.step_q};
         if (s.frac >= s.step_r) begin
            n.frac = s.frac - s.step_r;
         end else begin
            n.frac = s.frac + (den_eff - s.step_r);
            inc    = inc + 1'b1;
         end
         n.pos = s.pos - POS_W'(inc);
      end

      // Millisecond time base for the following-error timeout.
      n.tick = 1'b0;
      if (s.tick_cnt == TW'(TICK_CYCLES - 1)) begin
         n.tick_cnt = '0;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = s.tick_cnt + 1'b1;
      end

      diff = s.pos - $signed(act_pos);
      absd = diff[POS_W-1] ? POS_W'(-diff) : POS_W'(diff);
      if (closed_loop && absd > s.fe_win) begin
         if (s.tick && s.fe_cnt != 16'hFFFF) begin
            n.fe_cnt = s.fe_cnt + 1'b1;
         end
         if (s.fe_cnt > s.fe_tmo) begin
            n.fe = 1'b1;
         end
      end else begin
         n.fe_cnt = '0;
         n.fe     = 1'b0;
      end
      ev.follow = n.fe & ~s.fe;

      // Register reads; data stand only in the cycle after the strobe.
      case (addr)
         sdpi_pkg::OFF_MODE:       rdv = {24'h00_0000, s.mode};
         sdpi_pkg::OFF_SUBTYPE:    rdv = {31'h0000_0000, s.sub};
         sdpi_pkg::OFF_NUMER:      rdv = 32'(s.num);
         sdpi_pkg::OFF_DENOM:      rdv = 32'(s.den);
         sdpi_pkg::OFF_POS:        rdv = pos_rd;
         sdpi_pkg::OFF_FE_WINDOW:  rdv = 32'(s.fe_win);
         sdpi_pkg::OFF_FE_TIMEOUT: rdv = {16'h0000, s.fe_tmo};
         sdpi_pkg::OFF_STATUS: begin
            rdv[sdpi_pkg::SW_MODE_ACTIVE] = s.modeact;
            rdv[sdpi_pkg::SW_DIV_BUSY]    = s.dv_busy;
            rdv[sdpi_pkg::SW_FOLLOW_ERR]  = s.fe;
         end
         sdpi_pkg::OFF_EVENT:      rdv = 32'(s.evt);
         sdpi_pkg::OFF_MASK:       rdv = 32'(s.mask);
         sdpi_pkg::OFF_INVERT:     rdv = 32'(s.inv);
         sdpi_pkg::OFF_LIMIT_EN:   rdv = 32'(s.lim_en);
         sdpi_pkg::OFF_POLE_PAIRS: rdv = 32'(s.pp);
         sdpi_pkg::OFF_STEPS_REV:  rdv = 32'(s.pp) << sdpi_pkg::STEPS_PER_PP_SHIFT;
         sdpi_pkg::OFF_IN_LEVEL:   rdv = 32'(cond);
         default:                  rdv = '0;
      endcase
      n.rd_data = rd_en ? rdv : '0;

      // A read clears the sticky events; a new event in the same cycle survives.
      if (rd_en && addr == sdpi_pkg::OFF_EVENT) begin
         n.evt = '0;
      end
      n.evt = n.evt | ev;

      // Register writes.
      if (wr_en) begin
         case (addr)
            sdpi_pkg::OFF_MODE:       n.mode   = wdata[7:0];
            sdpi_pkg::OFF_SUBTYPE:    n.sub    = wdata[0];
            sdpi_pkg::OFF_NUMER:      n.num    = wdata[RATIO_W-1:0];
            sdpi_pkg::OFF_DENOM:      n.den    = wdata[RATIO_W-1:0];
            sdpi_pkg::OFF_POS: begin
               n.pos  = wdata[POS_W-1:0];
               n.frac = '0;
            end
            sdpi_pkg::OFF_FE_WINDOW:  n.fe_win = wdata[POS_W-1:0];
            sdpi_pkg::OFF_FE_TIMEOUT: n.fe_tmo = wdata[15:0];
            sdpi_pkg::OFF_MASK:       n.mask   = wdata[sdpi_pkg::EVT_W-1:0];
            sdpi_pkg::OFF_INVERT:     n.inv    = wdata[sdpi_pkg::NIN-1:0];
            sdpi_pkg::OFF_LIMIT_EN:   n.lim_en = wdata[1:0];
            sdpi_pkg::OFF_POLE_PAIRS: n.pp     = wdata[7:0];
            default: ;
         endcase
      end

      // Serial divider, one quotient bit per cycle; a new ratio restarts it.
      if (s.dv_busy) begin
         a_sh   = {s.dv_a, s.dv_q[RATIO_W-1]};
         n.dv_q = {s.dv_q[RATIO_W-2:0], 1'b0};
         if (a_sh >= {1'b0, den_eff}) begin
            a_sh      = a_sh - {1'b0, den_eff};
            n.dv_q[0] = 1'b1;
         end
         n.dv_a   = a_sh[RATIO_W-1:0];
         n.dv_cnt = s.dv_cnt - 1'b1;
         if (s.dv_cnt == 6'h01) begin
            n.dv_busy = 1'b0;
            n.step_q  = n.dv_q;
            n.step_r  = n.dv_a;
            n.frac    = '0;
         end
      end
      if (wr_en && (addr == sdpi_pkg::OFF_NUMER || addr == sdpi_pkg::OFF_DENOM)) begin
         n.dv_busy = 1'b1;
         n.dv_a    = '0;
         n.dv_q    = n.num;
         n.dv_cnt  = 6'(RATIO_W);
      end

      n.irq = |(n.evt & n.mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s        <= '0;
         s.num    <= RATIO_W'(sdpi_pkg::NUMER_RESET);
         s.den    <= RATIO_W'(sdpi_pkg::DENOM_RESET);
         s.step_q <= RATIO_W'(sdpi_pkg::NUMER_RESET / sdpi_pkg::DENOM_RESET);
         s.pp     <= sdpi_pkg::POLE_PAIRS_RST;
      end else begin
         s <= n;
      end
   end

   assign rd_data     = s.rd_data;
   assign cmd_pos     = s.pos;
   assign mode_active = s.modeact;
   assign follow_err  = s.fe;
   assign irq         = s.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_mode_entry: assert property (@(posedge clk) disable iff (!reset_n)
      (s.mode == sdpi_pkg::MODE_PULSE) |=> s.modeact)
      else $error("mode selector FFh did not activate the mode");

   a_hex_entry: assert property (@(posedge clk) disable iff (!reset_n)
      (s.lvl[sdpi_pkg::NIN +: sdpi_pkg::HEX_W] == HEX_MODE_CODE) |=> s.modeact)
      else $error("coding switch did not activate the mode");

   a_step_forward: assert property (@(posedge clk) disable iff (!reset_n)
      (mv_f && s.step_r == '0 && !wr_en) |=> (s.pos == $past(s.pos) + POS_W'($past(s.step_q))))
      else $error("forward pulse moved by the wrong amount");

   a_reset_ratio: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> (s.num == RATIO_W'(128) && s.den == RATIO_W'(1) && s.step_q == 8'd128))
      else $error("ratio after reset is not 128 over 1");

   a_full_step: assert property (@(posedge clk) disable iff (!reset_n)
      (s.step_q == RATIO_W'(sdpi_pkg::FULL_STEP) && s.step_r == '0 && mv_r && !wr_en)
      |=> (s.pos == $past(s.pos) - POS_W'(512)))
      else $error("full step ratio did not move 512 units");

   a_steps_rev: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_en && addr == sdpi_pkg::OFF_STEPS_REV && !wr_en)
      |=> (s.rd_data == 32'($past(s.pp)) * 4))
      else $error("steps per revolution is not four per pole pair");

   a_follow_set: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(s.fe) |-> ($past(closed_loop) && $past(s.fe_cnt) > $past(s.fe_tmo)))
      else $error("following error set without a timed-out excursion");

   a_dir_level: assert property (@(posedge clk) disable iff (!reset_n)
      (s.modeact && !s.sub && rise[sdpi_pkg::IN_PULSE] && !s.lvl[sdpi_pkg::IN_DIRECTION]
       && !blocked && !wr_en) |=> (s.pos < $past(s.pos) || $past(s.pos) == $past(s.pos) - 1'b1))
      else $error("low direction level did not move backwards");

   a_dual_reverse: assert property (@(posedge clk) disable iff (!reset_n)
      (s.modeact && s.sub && rise[sdpi_pkg::IN_DIRECTION] && !rise[sdpi_pkg::IN_PULSE]
       && !blocked) |-> mv_r)
      else $error("edge on the second input did not move backwards");

   a_limit_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (blocked && !wr_en) |=> (s.pos == $past(s.pos) && s.evt.limit))
      else $error("pulse moved past an active limit switch");

   a_pin_select: assert property (@(posedge clk) disable iff (!reset_n)
      (mv_f && !s.sub) |-> (s.sy[2][sdpi_pkg::IN_PULSE] && s.lvl[sdpi_pkg::IN_DIRECTION]))
      else $error("pulse taken from the wrong pin or polarity");

   a_sync_depth: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(s.lvl[sdpi_pkg::IN_PULSE]) |-> ($past(s.sy[1][sdpi_pkg::IN_PULSE])
                                           && $past(s.sy[2][sdpi_pkg::IN_PULSE])))
      else $error("pulse level accepted before two stages agreed");

endmodule

//--- tb_top.sv
// Self-checking testbench of the step and direction pulse input.
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        reset_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rd_data;
   logic [1:0]  src_lines;
   logic        lim;
   logic [3:0]  hex_pin;
   logic        closed_loop;
   logic [31:0] act_pos;
   logic [31:0] cmd_pos;
   logic        mode_active;
   logic        follow_err;
   logic        irq;
   logic [31:0] d;
   int          checks;
   int          miscompares;

   sdpi_top #(.TICK_CYCLES(20)) dut (
      .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .in_pin({3'h0, src_lines, lim}),
      .hex_pin(hex_pin), .closed_loop(closed_loop), .act_pos(act_pos),
      .cmd_pos(cmd_pos), .mode_active(mode_active), .follow_err(follow_err), .irq(irq));

   sdpi_step_src src (.lines(src_lines));

   // -----------------------------------------------------------------
   // Bus and check tasks
   // -----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   task automatic end_of_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // The divider runs after a ratio write; pulses before it ends would use the old step.
   task automatic wait_div;
      logic [31:0] v;
      for (int i = 0; i < 40; i++) begin
         rd(sdpi_pkg::OFF_STATUS, v);
         if (v[sdpi_pkg::SW_DIV_BUSY] === 1'b0)
            return;
      end
      miscompares++;
      end_of_test();
   endtask

   task automatic wait_fe(input logic v);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if (follow_err === v)
            return;
      end
      miscompares++;
      end_of_test();
   endtask

   // -----------------------------------------------------------------
   // Clock, reset and watchdog
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #2000000;
      miscompares++;
      end_of_test();
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      reset_n = 1'b0; addr = 8'h00; wdata = 32'h0000_0000; wr_en = 1'b0; rd_en = 1'b0;
      lim = 1'b0; hex_pin = 4'h0; closed_loop = 1'b0; act_pos = 32'h0000_0000;
      checks = 0; miscompares = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rdc(sdpi_pkg::OFF_NUMER, 32'h0000_0080);
      rdc(sdpi_pkg::OFF_DENOM, 32'h0000_0001);
      rdc(sdpi_pkg::OFF_STEPS_REV, 32'h0000_00C8);
      src.burst(2, 1'b1, 1'b0);
      chk(cmd_pos, 32'h0000_0000);
      wr(sdpi_pkg::OFF_MODE, 32'h0000_00FF);
      repeat (3) @(posedge clk);
      chk(32'(mode_active), 32'h0000_0001);
      wr(sdpi_pkg::OFF_INVERT, 32'h0000_0006);
      src.burst(4, 1'b1, 1'b0);
      chk(cmd_pos, 32'h0000_0200);
      rdc(sdpi_pkg::OFF_EVENT, 32'h0000_0001);
      rdc(sdpi_pkg::OFF_EVENT, 32'h0000_0000);
      wr(sdpi_pkg::OFF_MASK, 32'h0000_0001);
      src.burst(1, 1'b1, 1'b0);
      chk(32'(irq), 32'h0000_0001);
      rdc(sdpi_pkg::OFF_EVENT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      wr(sdpi_pkg::OFF_NUMER, 32'h0000_0200);
      wait_div();
      src.burst(3, 1'b0, 1'b0);
      chk(cmd_pos, 32'hFFFF_FC80);
      wr(sdpi_pkg::OFF_POS, 32'h0000_0000);
      wr(sdpi_pkg::OFF_SUBTYPE, 32'h0000_0001);
      src.burst(2, 1'b1, 1'b1);
      chk(cmd_pos, 32'h0000_0400);
      src.burst(1, 1'b0, 1'b1);
      chk(cmd_pos, 32'h0000_0200);
      wr(sdpi_pkg::OFF_SUBTYPE, 32'h0000_0000);
      wr(sdpi_pkg::OFF_POS, 32'h0000_0000);
      wr(sdpi_pkg::OFF_NUMER, 32'h0000_0003);
      wr(sdpi_pkg::OFF_DENOM, 32'h0000_0002);
      wait_div();
      src.burst(2, 1'b1, 1'b0);
      chk(cmd_pos, 32'h0000_0003);
      rd(sdpi_pkg::OFF_EVENT, d);
      wr(sdpi_pkg::OFF_LIMIT_EN, 32'h0000_0001);
      lim <= 1'b1;
      src.burst(1, 1'b0, 1'b0);
      chk(cmd_pos, 32'h0000_0003);
      rd(sdpi_pkg::OFF_EVENT, d);
      chk(d & 32'h0000_000C, 32'h0000_0008);
      @(posedge clk);
      lim <= 1'b0;
      wr(sdpi_pkg::OFF_POLE_PAIRS, 32'h0000_0003);
      wr(sdpi_pkg::OFF_STEPS_REV, 32'h0000_0055);
      rdc(sdpi_pkg::OFF_STEPS_REV, 32'h0000_000C);
      wr(sdpi_pkg::OFF_FE_TIMEOUT, 32'h0000_0001);
      closed_loop <= 1'b1;
      wait_fe(1'b1);
      rd(sdpi_pkg::OFF_STATUS, d);
      chk(32'(d[sdpi_pkg::SW_FOLLOW_ERR]), 32'h0000_0001);
      rdc(sdpi_pkg::OFF_EVENT, 32'h0000_0002);
      @(posedge clk);
      act_pos <= 32'h0000_0003;
      wait_fe(1'b0);
      @(posedge clk);
      closed_loop <= 1'b0;
      src.hasty(1'b1);
      chk(cmd_pos, 32'h0000_0004);
      rdc(sdpi_pkg::OFF_EVENT, 32'h0000_0005);
      wr(sdpi_pkg::OFF_MODE, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk(32'(mode_active), 32'h0000_0000);
      hex_pin <= 4'h1;
      repeat (8) @(posedge clk);
      chk(32'(mode_active), 32'h0000_0001);
      rdc(8'hFC, 32'h0000_0000);
      end_of_test();
   end
endmodule
